//--- hdl/bmr_top.sv
// Notes on behaviour
// - Field bits 9-8 pick the time stamp point; 00 means last bit of last word.
// - Every time stamp is taken at the middle of the chosen bit.
// - Code 01 stamps at the first bit, half a microsecond after the end of sync.
// - Code 10 stamps last bit of first word; last bit is before parity.
// - Code 11 turns stamping off; each record carries a zero time tag.
// - A record may open on a data word; it is then the first word.
// - Start code 00 opens only on a complete, valid, odd parity command word.
// - Start code 01 opens on any complete valid word of either sync type.
// - Codes 01 and 11 set sync error when the record opens on data sync.
// - Code 10 opens on command sync plus two bits; bad word flags invalid.
// - Code 11 opens on any sync plus two bits; bad Manchester flags invalid.
// - Keep bit clear: invalid word ends the message, word dropped, rearm start.
// - Keep bit set: invalid word is stored and the message continues.
// - All three fields live in the configuration register at index 0x29.
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`include "bmr_consts.svh"
`default_nettype none

module bmr_top (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire bmr_pkg::bmr_dec_t i_dec,
  output bmr_pkg::bmr_rec_t o_rec,
  output logic o_irq
);
  import bmr_pkg::*;

  localparam int FB_CYC = `BMR_FIRST_BIT_CYC;

  // ****************************************
  // State and helpers
  // ****************************************
  bmr_top_state_t s;
  bmr_top_state_t n;
  bmr_qual_t qual;
  logic [15:0] ttag_count;
  bmr_tagpt_t tagpt;
  bmr_start_t start_code;
  logic keep;
  logic word_good;
  logic bad;
  logic store;
  logic first_now;
  logic abort;
  logic [2:0] ev;
  logic [5:0] reg_idx;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [15:0] cfg_wmask;

  // Configuration fields decoded from the live register
  assign tagpt = bmr_tagpt_t'(s.cfg[`BMR_CFG_TTB_LSB +: 2]);
  assign start_code = bmr_start_t'(s.cfg[`BMR_CFG_SRR_LSB +: 2]);
  assign keep = s.cfg[`BMR_CFG_KEEP_BIT];
  assign word_good = i_dec.word_ok && i_dec.parity_ok;

  // ****************************************
  // Submodules
  // ****************************************
  bmr_ttag i_bmr_ttag (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .o_count(ttag_count)
  );

  bmr_start_qual i_bmr_start_qual (
    .i_code(start_code),
    .i_dec(i_dec),
    .o_qual(qual)
  );

  // ****************************************
  // Register bus decode
  // ****************************************
  assign reg_idx = i_avs_address[7:2];
  assign addr_ok = (i_avs_address[1:0] == 2'h0);
  assign cfg_wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  // Read data selection; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_ok) begin
      unique case (reg_idx)
        `BMR_IDX_CFG: rd_mux = {16'h0000, s.cfg | 16'h0001};
        `BMR_IDX_STS: rd_mux = {29'h0000_0000, s.sts};
        `BMR_IDX_MSK: rd_mux = {29'h0000_0000, s.msk};
        `BMR_IDX_TTAG: rd_mux = {16'h0000, ttag_count};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = s;
    n.rec.word_vld = 1'b0;
    n.rec.msg_vld = 1'b0;
    ev = 3'h0;
    bad = 1'b0;
    store = 1'b0;
    abort = 1'b0;
    first_now = s.first;

    // First-bit instant counted from the end of every sync
    if (i_dec.sync_det) begin
      n.fb_run = 1'b1;
      n.fb_cnt = 7'(`BMR_FIRST_BIT_CYC);
    end else if (s.fb_run) begin
      if (s.fb_cnt == 7'h01) begin
        n.fb_run = 1'b0;
        n.cand1 = ttag_count;
      end else begin
        n.fb_cnt = s.fb_cnt - 7'h01;
      end
    end

    // Mid-bit of the last data bit, ahead of the parity bit
    if (i_dec.last_mid) begin
      n.cand16 = ttag_count;
    end

    unique case (s.st)
      BMR_ST_IDLE: begin
        if (qual.start) begin
          n.st = BMR_ST_REC;
          n.first = 1'b1;
          n.frag = qual.frag;
          n.bsw = 16'h0000;
          first_now = 1'b1;
          if (qual.sync_err) begin
            n.bsw[`BMR_BSW_SYNC] = 1'b1;
            ev[`BMR_EV_SYNC] = 1'b1;
          end
          // A data word may open the record and counts as first word
          if (tagpt == BMR_TP_FIRST_OF_FIRST) begin
            n.tag = s.cand1;
          end else begin
            n.tag = s.cand16;
          end
          store = !qual.frag;
        end
      end
      BMR_ST_REC: begin
        if (i_dec.word_end) begin
          if (s.first && s.frag) begin
            // Fragment start: first word stored whatever its state
            if (start_code == BMR_SC_CMD_FRAG) begin
              bad = !(word_good && i_dec.sync_cmd);
            end else begin
              bad = !i_dec.word_ok;
            end
            store = 1'b1;
          end else begin
            bad = !word_good;
            store = !bad || keep;
            abort = bad && !keep;
          end
        end
      end
    endcase

    // Store a word into the record stream and move the tag point
    if (store) begin
      n.rec.word_vld = 1'b1;
      n.rec.word = i_dec.word;
      n.rec.word_cmd = i_dec.sync_cmd;
      n.rec.word_bad = bad;
      n.first = 1'b0;
      if (bad) begin
        n.bsw[`BMR_BSW_BAD] = 1'b1;
        ev[`BMR_EV_BAD] = 1'b1;
      end
      if (tagpt == BMR_TP_LAST_OF_LAST) begin
        n.tag = s.cand16;
      end else if (first_now && tagpt == BMR_TP_LAST_OF_FIRST) begin
        n.tag = s.cand16;
      end
    end

    // Close the message on completion, time-out or an unkept bad word
    if (s.st == BMR_ST_REC && (abort || i_dec.msg_end || i_dec.timeout)) begin
      n.st = BMR_ST_IDLE;
      n.rec.msg_vld = 1'b1;
      n.rec.bsw = n.bsw;
      if (abort) begin
        n.rec.bsw[`BMR_BSW_BAD] = 1'b1;
        ev[`BMR_EV_BAD] = 1'b1;
      end
      n.rec.ttag = (tagpt == BMR_TP_OFF) ? 16'h0000 : n.tag;
      ev[`BMR_EV_MSG] = 1'b1;
    end

    // Avalon handshake: one wait cycle, then the request is taken
    n.wait_req = 1'b1;
    if ((i_avs_read || i_avs_write) && s.wait_req) begin
      n.wait_req = 1'b0;
      n.rdata = rd_mux;
    end

    // Register writes take effect when waitrequest is seen low
    n.sts = s.sts | ev;
    if (i_avs_write && !s.wait_req && addr_ok) begin
      unique case (reg_idx)
        `BMR_IDX_CFG: begin
          n.cfg = (s.cfg & ~cfg_wmask) | (i_avs_writedata[15:0] & cfg_wmask);
          n.cfg[`BMR_CFG_ONE_BIT] = 1'b0;
        end
        `BMR_IDX_STS: begin
          if (i_avs_byteenable[0]) begin
            n.sts = (s.sts & ~i_avs_writedata[2:0]) | ev;
          end
        end
        `BMR_IDX_MSK: begin
          if (i_avs_byteenable[0]) begin
            n.msk = i_avs_writedata[2:0];
          end
        end
        default: begin
        end
      endcase
    end
    n.irq = |(n.sts & n.msk);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      s <= '0;
      s.st <= BMR_ST_IDLE;
      s.wait_req <= 1'b1;
      s.cfg <= `BMR_CFG_RST;
      s.sts <= `BMR_STS_RST;
      s.msk <= `BMR_MSK_RST;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign o_avs_readdata = s.rdata;
  assign o_avs_waitrequest = s.wait_req;
  assign o_rec = s.rec;
  assign o_irq = s.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  sequence seq_idle_word;
    s.st == BMR_ST_IDLE && i_dec.word_end;
  endsequence

  sequence seq_rec_word;
    s.st == BMR_ST_REC && i_dec.word_end && !i_dec.msg_end && !i_dec.timeout;
  endsequence

  AST_TAG_OFF_ZERO: assert property (
    o_rec.msg_vld && $past(tagpt) == BMR_TP_OFF |-> o_rec.ttag == 16'h0000)
    else $error("time tag not zero while tagging is off");

  AST_FIRST_BIT_ARM: assert property (
    i_dec.sync_det |=> s.fb_run && s.fb_cnt == 7'(FB_CYC))
    else $error("first bit counter not armed at sync end");

  AST_FIRST_BIT_CAPTURE: assert property (
    s.fb_run && s.fb_cnt == 7'h01 && !i_dec.sync_det
    |=> !s.fb_run && s.cand1 == $past(ttag_count))
    else $error("first bit count not latched at its instant");

  AST_START_CMD_ONLY: assert property (
    seq_idle_word ##0 start_code == BMR_SC_CMD_WORD
    && !(i_dec.sync_cmd && word_good) |=> s.st == BMR_ST_IDLE && !o_rec.word_vld)
    else $error("record opened without a valid command word");

  AST_START_ANY_WORD: assert property (
    seq_idle_word ##0 start_code == BMR_SC_ANY_WORD && word_good
    |=> s.st == BMR_ST_REC && o_rec.word_vld && o_rec.word == $past(i_dec.word))
    else $error("valid word did not open a record");

  AST_SYNC_ERROR: assert property (
    s.st == BMR_ST_IDLE && qual.start && !i_dec.sync_cmd
    && (start_code == BMR_SC_ANY_WORD || start_code == BMR_SC_ANY_FRAG)
    |=> s.bsw[`BMR_BSW_SYNC])
    else $error("data sync start without sync error");

  AST_FRAG_CMD_START: assert property (
    s.st == BMR_ST_IDLE && start_code == BMR_SC_CMD_FRAG && i_dec.two_bits
    && i_dec.sync_cmd |=> s.st == BMR_ST_REC && s.first && s.frag)
    else $error("command fragment did not open a record");

  AST_DROP_BAD: assert property (
    seq_rec_word ##0 !keep && !word_good && !(s.first && s.frag)
    |=> s.st == BMR_ST_IDLE && !o_rec.word_vld && o_rec.msg_vld
    && o_rec.bsw[`BMR_BSW_BAD])
    else $error("bad word not dropped with message closed");

  AST_KEEP_BAD: assert property (
    seq_rec_word ##0 keep && !word_good
    && !(s.first && s.frag && start_code != BMR_SC_CMD_FRAG && i_dec.word_ok)
    |=> s.st == BMR_ST_REC && o_rec.word_vld && o_rec.word_bad)
    else $error("bad word not kept while continue is set");

  AST_IRQ_LEVEL: assert property (
    s.sts[`BMR_EV_MSG] && s.msk[`BMR_EV_MSG] && !(i_avs_write && !s.wait_req)
    |=> o_irq)
    else $error("interrupt low with unmasked status set");

  // Register bus: one wait cycle, then exactly one answer cycle
  AST_WAIT_ANSWER: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");

  AST_WAIT_ONE: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // Time stamp point and invalid flag of the first fragment word
  AST_TAG_LAST_WORD: assert property (
    s.st == BMR_ST_REC && i_dec.word_end && word_good && tagpt == BMR_TP_LAST_OF_LAST
    |=> s.tag == $past(s.cand16))
    else $error("tag not taken from the last word");

  AST_FRAG_FIRST_BAD: assert property (
    seq_rec_word ##0 s.first && s.frag && start_code == BMR_SC_CMD_FRAG
    && !(word_good && i_dec.sync_cmd) |=> o_rec.word_vld && o_rec.word_bad)
    else $error("bad command fragment not flagged invalid");
endmodule : bmr_top

`default_nettype wire

//--- hdl/bmr_consts.svh
`ifndef BMR_CONSTS_SVH
`define BMR_CONSTS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define BMR_CLK_PERIOD_NS 8
`define BMR_FIRST_BIT_NS 500
`define BMR_FIRST_BIT_CYC ((`BMR_FIRST_BIT_NS) / (`BMR_CLK_PERIOD_NS))
`define BMR_TTAG_TICK_NS 1000
`define BMR_TTAG_TICK_CYC ((`BMR_TTAG_TICK_NS) / (`BMR_CLK_PERIOD_NS))

// ****************************************
// Register indexes (byte address is four times the index)
// ****************************************
`define BMR_IDX_CFG 6'h29
`define BMR_IDX_STS 6'h2A
`define BMR_IDX_MSK 6'h2B
`define BMR_IDX_TTAG 6'h3A

// ****************************************
// Configuration fields and reset values
// ****************************************
`define BMR_CFG_TTB_LSB 8
`define BMR_CFG_SRR_LSB 5
`define BMR_CFG_KEEP_BIT 4
`define BMR_CFG_ONE_BIT 0
`define BMR_CFG_RST 16'h0000
`define BMR_STS_RST 3'h0
`define BMR_MSK_RST 3'h0

// ****************************************
// Event and block status bits
// ****************************************
`define BMR_EV_MSG 0
`define BMR_EV_BAD 1
`define BMR_EV_SYNC 2
`define BMR_BSW_BAD 0
`define BMR_BSW_SYNC 1

`endif

//--- hdl/bmr_pkg.sv
`default_nettype none

package bmr_pkg;
  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic [1:0] {
    BMR_TP_LAST_OF_LAST = 2'h0,
    BMR_TP_FIRST_OF_FIRST = 2'h1,
    BMR_TP_LAST_OF_FIRST = 2'h2,
    BMR_TP_OFF = 2'h3
  } bmr_tagpt_t;

  typedef enum logic [1:0] {
    BMR_SC_CMD_WORD = 2'h0,
    BMR_SC_ANY_WORD = 2'h1,
    BMR_SC_CMD_FRAG = 2'h2,
    BMR_SC_ANY_FRAG = 2'h3
  } bmr_start_t;

  typedef enum logic [0:0] {
    BMR_ST_IDLE = 1'h0,
    BMR_ST_REC = 1'h1
  } bmr_fsm_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic sync_det;
    logic sync_cmd;
    logic two_bits;
    logic last_mid;
    logic word_end;
    logic word_ok;
    logic parity_ok;
    logic [15:0] word;
    logic msg_end;
    logic timeout;
  } bmr_dec_t;

  typedef struct packed {
    logic start;
    logic sync_err;
    logic frag;
  } bmr_qual_t;

  typedef struct packed {
    logic word_vld;
    logic word_cmd;
    logic word_bad;
    logic [15:0] word;
    logic msg_vld;
    logic [15:0] bsw;
    logic [15:0] ttag;
  } bmr_rec_t;

  typedef struct packed {
    logic [6:0] pre;
    logic [15:0] cnt;
  } bmr_ttag_state_t;

  typedef struct packed {
    bmr_fsm_t st;
    logic first;
    logic frag;
    logic fb_run;
    logic [6:0] fb_cnt;
    logic [15:0] cand1;
    logic [15:0] cand16;
    logic [15:0] tag;
    logic [15:0] bsw;
    bmr_rec_t rec;
    logic wait_req;
    logic [31:0] rdata;
    logic [15:0] cfg;
    logic [2:0] sts;
    logic [2:0] msk;
    logic irq;
  } bmr_top_state_t;
endpackage : bmr_pkg

`default_nettype wire

//--- hdl/bmr_ttag.sv
`include "bmr_consts.svh"
`default_nettype none

module bmr_ttag (
  input wire logic i_clock,
  input wire logic i_rst_b,
  output logic [15:0] o_count
);
  import bmr_pkg::*;

  bmr_ttag_state_t s;
  bmr_ttag_state_t n;

  // Free-running count advancing once per microsecond
  always_comb begin
    n = s;
    if (s.pre == 7'(`BMR_TTAG_TICK_CYC - 1)) begin
      n.pre = 7'h00;
      n.cnt = s.cnt + 16'h0001;
    end else begin
      n.pre = s.pre + 7'h01;
    end
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_count = s.cnt;
endmodule : bmr_ttag

`default_nettype wire

//--- hdl/bmr_start_qual.sv
`default_nettype none

module bmr_start_qual (
  input wire bmr_pkg::bmr_start_t i_code,
  input wire bmr_pkg::bmr_dec_t i_dec,
  output bmr_pkg::bmr_qual_t o_qual
);
  import bmr_pkg::*;

  // Decide whether the current bus event opens a new record
  always_comb begin
    o_qual = '0;
    unique case (i_code)
      BMR_SC_CMD_WORD: begin
        o_qual.start = i_dec.word_end && i_dec.sync_cmd && i_dec.word_ok
          && i_dec.parity_ok;
      end
      BMR_SC_ANY_WORD: begin
        o_qual.start = i_dec.word_end && i_dec.word_ok && i_dec.parity_ok;
        o_qual.sync_err = !i_dec.sync_cmd;
      end
      BMR_SC_CMD_FRAG: begin
        o_qual.start = i_dec.two_bits && i_dec.sync_cmd;
        o_qual.frag = 1'b1;
      end
      BMR_SC_ANY_FRAG: begin
        o_qual.start = i_dec.two_bits;
        o_qual.sync_err = !i_dec.sync_cmd;
        o_qual.frag = 1'b1;
      end
    endcase
  end
endmodule : bmr_start_qual

`default_nettype wire

//--- tb/bmr_dec_model.sv
`default_nettype none

module bmr_dec_model (
  input wire logic i_clock,
  input wire logic i_rst_b,
  output bmr_pkg::bmr_dec_t o_dec
);
  timeunit 1ns;
  timeprecision 1ps;
  import bmr_pkg::*;

  // ****************************************
  // Word decoder stand-in, one bit time = 125 cycles
  // ****************************************
  int cyc;
  int t_sync;
  int t_mid_first;
  int t_mid_last;

  // Cycles since reset release, used for time tag expectations
  always @(posedge i_clock) begin
    cyc <= i_rst_b ? cyc + 1 : 0;
  end

  // Quiet bus at time zero
  initial begin
    o_dec = '0;
  end

  // One word: sync, two data bits, mid of data bit 16, end of parity
  task automatic send(input logic cmd, input logic ok, input logic par,
                      input logic [15:0] w, input logic first);
    @(posedge i_clock);
    o_dec.sync_det <= 1'h1;
    o_dec.sync_cmd <= cmd;
    if (first) begin
      t_sync = cyc + 1;
    end
    @(posedge i_clock);
    o_dec.sync_det <= 1'h0;
    repeat (249) @(posedge i_clock);
    o_dec.two_bits <= 1'h1;
    @(posedge i_clock);
    o_dec.two_bits <= 1'h0;
    repeat (1686) @(posedge i_clock);
    o_dec.last_mid <= 1'h1;
    t_mid_last = cyc + 1;
    if (first) begin
      t_mid_first = cyc + 1;
    end
    @(posedge i_clock);
    o_dec.last_mid <= 1'h0;
    repeat (186) @(posedge i_clock);
    {o_dec.word_end, o_dec.word_ok, o_dec.parity_ok} <= {1'h1, ok, par};
    o_dec.word <= w;
    @(posedge i_clock);
    // Word lines no longer valid: show the inverse, not the old value
    {o_dec.word_end, o_dec.word_ok, o_dec.parity_ok} <= {1'h0, ~ok, ~par};
    o_dec.word <= ~w;
    repeat (100) @(posedge i_clock);
  endtask : send

  // Message completes, or the response time-out fires
  task automatic finish(input logic to);
    @(posedge i_clock);
    o_dec.timeout <= to;
    o_dec.msg_end <= ~to;
    @(posedge i_clock);
    o_dec.timeout <= 1'h0;
    o_dec.msg_end <= 1'h0;
    repeat (4) @(posedge i_clock);
  endtask : finish
endmodule : bmr_dec_model

`default_nettype wire

//--- tb/tb_bmr_top.sv
`default_nettype none

module tb_bmr_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bmr_pkg::*;

  logic clock;
  logic rst_b;
  logic [7:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wdat;
  logic [3:0] ben;
  logic [31:0] rdat_w;
  logic wreq;
  logic irq;
  logic [31:0] rdat;
  bmr_dec_t dec;
  bmr_rec_t rec;
  bmr_rec_t w_last;
  bmr_rec_t m_last;
  int n_word;
  int n_msg;
  int n_mismatch;
  int cmp_count;

  bmr_top i_bmr_top (.i_clock(clock), .i_rst_b(rst_b), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(ben), .o_avs_readdata(rdat_w), .o_avs_waitrequest(wreq),
    .i_dec(dec), .o_rec(rec), .o_irq(irq));
  bmr_dec_model i_bmr_dec_model (.i_clock(clock), .i_rst_b(rst_b), .o_dec(dec));

  // ****************************************
  // Clock, record monitor, watchdog
  // ****************************************
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  // Count record pulses in the cycle they stand
  always @(posedge clock) begin
    if (rec.word_vld === 1'h1) begin
      n_word++;
      w_last = rec;
    end
    if (rec.msg_vld === 1'h1) begin
      n_msg++;
      m_last = rec;
    end
  end

  // About 38k cycles of traffic expected
  initial begin
    repeat (80000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Avalon access held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wdat <= d;
    @(posedge clock);
    while (wreq !== 1'h0) begin
      n++;
      @(posedge clock);
    end
    check(n, 1);
    rdat = rdat_w;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    check(rdat, exp);
  endtask : rd_chk

  // Unused bits 7 and 3 always written as zero
  task automatic cfg(input logic [1:0] tp, input logic [1:0] sc, input logic keep);
    bus(1'h1, 8'hA4, {22'h0, tp, 1'h0, sc, keep, 4'h0});
    n_word = 0;
    n_msg = 0;
  endtask : cfg

  task automatic counts(input int w, input int m);
    check(n_word, w);
    check(n_msg, m);
  endtask : counts

  // Time tag may sit one count either side of the cycle estimate
  task automatic tag(input int cyc, input logic [15:0] got);
    logic [15:0] e;
    e = 16'(cyc / 125);
    cmp_count++;
    if (!(got === e || got === e + 16'h1 || got === e - 16'h1)) begin
      n_mismatch++;
      $display("unexpected at %0t: tag %h near %h", $time, got, e);
    end
  endtask : tag

  task automatic irq_is(input logic v);
    repeat (3) @(posedge clock);
    check({31'h0, irq}, {31'h0, v});
  endtask : irq_is

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {rst_b, rd, wr, adr, wdat} = '0;
    ben = 4'hF;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (8) @(posedge clock);
    rst_b <= 1'h1;
    rd_chk(8'hA4, 32'h1);
    rd_chk(8'hA8, 32'h0);
    rd_chk(8'hAC, 32'h0);
    rd_chk(8'h10, 32'h0);
    cfg(2'h2, 2'h3, 1'h1);
    rd_chk(8'hA4, 32'h271);
    // Only the low byte lane is written; bits 9-8 keep their value
    ben <= 4'h1;
    bus(1'h1, 8'hA4, 32'h0000_0310);
    ben <= 4'hF;
    rd_chk(8'hA4, 32'h211);
    // Misaligned accesses are answered, read zero and write nothing
    bus(1'h1, 8'hA7, 32'h0000_0300);
    rd_chk(8'hA4, 32'h211);
    rd_chk(8'hA6, 32'h0);
    // Running time tag count readable at its own index
    bus(1'h0, 8'hE8, 32'h0);
    tag(i_bmr_dec_model.cyc, rdat[15:0]);
    $display("registers done");
    // Code 00: data word and bad parity ignored, tagging off
    cfg(2'h3, 2'h0, 1'h0);
    i_bmr_dec_model.send(1'h0, 1'h1, 1'h1, 16'h1234, 1'h1);
    i_bmr_dec_model.send(1'h1, 1'h1, 1'h0, 16'h1234, 1'h1);
    i_bmr_dec_model.send(1'h1, 1'h1, 1'h1, 16'hA5C3, 1'h1);
    i_bmr_dec_model.finish(1'h0);
    counts(1, 1);
    check({w_last.word_cmd, w_last.word}, 32'h1A5C3);
    check({m_last.bsw, m_last.ttag}, 32'h0);
    $display("start code 00 done");
    // Code 01: record opens on data sync, tag at last word
    cfg(2'h0, 2'h1, 1'h0);
    i_bmr_dec_model.send(1'h0, 1'h1, 1'h1, 16'h00FF, 1'h1);
    i_bmr_dec_model.send(1'h0, 1'h1, 1'h1, 16'h0F0F, 1'h0);
    i_bmr_dec_model.finish(1'h0);
    counts(2, 1);
    check({16'h0, m_last.bsw}, 32'h2);
    tag(i_bmr_dec_model.t_mid_last, m_last.ttag);
    $display("start code 01 done");
    // Code 10: data fragment ignored, bad command fragment recorded
    cfg(2'h2, 2'h2, 1'h1);
    i_bmr_dec_model.send(1'h0, 1'h0, 1'h0, 16'h5555, 1'h0);
    i_bmr_dec_model.send(1'h1, 1'h0, 1'h1, 16'h0C0C, 1'h1);
    i_bmr_dec_model.send(1'h0, 1'h1, 1'h1, 16'h0001, 1'h0);
    i_bmr_dec_model.finish(1'h0);
    counts(2, 1);
    check({16'h0, m_last.bsw}, 32'h1);
    tag(i_bmr_dec_model.t_mid_first, m_last.ttag);
    $display("start code 10 done");
    // Code 11: bad data fragment opens, closed by time-out
    cfg(2'h1, 2'h3, 1'h1);
    i_bmr_dec_model.send(1'h0, 1'h0, 1'h1, 16'h7E7E, 1'h1);
    i_bmr_dec_model.finish(1'h1);
    counts(1, 1);
    check({16'h0, m_last.bsw}, 32'h3);
    tag(i_bmr_dec_model.t_sync + 62, m_last.ttag);
    $display("start code 11 done");
    // Invalid word with keep clear ends the message
    cfg(2'h3, 2'h0, 1'h0);
    i_bmr_dec_model.send(1'h1, 1'h1, 1'h1, 16'h2001, 1'h1);
    i_bmr_dec_model.send(1'h0, 1'h0, 1'h1, 16'h3333, 1'h0);
    counts(1, 1);
    check({16'h0, m_last.bsw}, 32'h1);
    i_bmr_dec_model.send(1'h0, 1'h1, 1'h1, 16'h4444, 1'h0);
    counts(1, 1);
    i_bmr_dec_model.send(1'h1, 1'h1, 1'h1, 16'h2002, 1'h1);
    i_bmr_dec_model.finish(1'h0);
    counts(2, 2);
    $display("keep clear done");
    // Invalid word with keep set is stored, message goes on
    cfg(2'h3, 2'h0, 1'h1);
    i_bmr_dec_model.send(1'h1, 1'h1, 1'h1, 16'h2003, 1'h1);
    i_bmr_dec_model.send(1'h0, 1'h0, 1'h1, 16'h6666, 1'h0);
    counts(2, 0);
    check({15'h0, w_last.word_bad, w_last.word}, 32'h16666);
    i_bmr_dec_model.send(1'h0, 1'h1, 1'h1, 16'h7777, 1'h0);
    i_bmr_dec_model.finish(1'h1);
    counts(3, 1);
    $display("keep set done");
    // Interrupt: sticky status, mask, write one to clear
    rd_chk(8'hA8, 32'h7);
    bus(1'h1, 8'hAC, 32'h1);
    irq_is(1'h1);
    bus(1'h1, 8'hA8, 32'h7);
    irq_is(1'h0);
    rd_chk(8'hA8, 32'h0);
    cfg(2'h3, 2'h0, 1'h0);
    i_bmr_dec_model.send(1'h1, 1'h1, 1'h1, 16'h2004, 1'h1);
    i_bmr_dec_model.finish(1'h0);
    irq_is(1'h1);
    rd_chk(8'hA8, 32'h1);
    bus(1'h1, 8'hAC, 32'h0);
    irq_is(1'h0);
    $display("interrupt done");
    wrap_up();
  end
endmodule : tb_bmr_top

`default_nettype wire
